// ==== core/blcf_pkg.sv ====
package blcf_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS   = 25;
  localparam int CHECK_SETTLE_NS  = 1_000_000;
  localparam int CHECK_SETTLE_CYC =
    (CHECK_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CHK_CNT_W        = 20;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam int            APB_AW        = 16;
  localparam logic [15:0]   IDX_IRQ_STAT  = 16'h0000;
  localparam logic [15:0]   IDX_IRQ_MASK  = 16'h0001;
  localparam logic [15:0]   IDX_CHK_STATE = 16'h0002;
  localparam logic [15:0]   IDX_CONTROL   = 16'h1FF8;
  localparam logic [15:0]   IDX_CLOCK     = 16'h1FFC;
  localparam logic [15:0]   IDX_FLAGS     = 16'h1FFD;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_WRITE_HALT  = 7;
  localparam int BIT_CENT_ENABLE = 5;
  localparam int BIT_CENT_FLAG   = 4;
  localparam int BIT_BATLOW_EN   = 7;
  localparam int BIT_BATLOW_FLAG = 6;
  localparam int BIT_CHK_BUSY    = 0;
  localparam int BIT_MAINS_GOOD  = 1;
  localparam int IRQ_W           = 3;
  localparam int IRQ_BATLOW      = 0;
  localparam int IRQ_CENTURY     = 1;
  localparam int IRQ_CHK_DONE    = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic             RST_BATLOW_EN   = 1'b0;
  localparam logic             RST_BATLOW_FLAG = 1'b0;
  localparam logic             RST_CENT_ENABLE = 1'b0;
  localparam logic             RST_CENT_FLAG   = 1'b0;
  localparam logic             RST_WRITE_HALT  = 1'b0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK    = 3'h0;
  localparam logic [31:0]      ZERO_WORD       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BLCF_CHK_OFF,
    BLCF_CHK_SETTLE,
    BLCF_CHK_IDLE
  } blcf_chk_state_t;

  typedef struct packed {
    blcf_chk_state_t       state;
    logic [CHK_CNT_W-1:0]  cnt;
    logic                  done;
    logic                  low;
  } blcf_chk_st_t;

  typedef struct packed {
    logic             ready;
    logic [31:0]      rdata;
    logic             slverr;
    logic             batLowEn;
    logic             batLowFlag;
    logic             centEnable;
    logic             centFlag;
    logic             writeHalt;
    logic             load;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic             irq;
  } blcf_top_st_t;

endpackage

// ==== core/blcf_batt_check.sv ====
`timescale 1ns/1ps
module blcf_batt_check
  import blcf_pkg::*;
#(
  parameter int SETTLE_CYC = CHECK_SETTLE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic mainsGood,
  input  wire logic batteryBelow,
  output logic      chkDone,
  output logic      chkLow,
  output logic      chkBusy
);

  blcf_chk_st_t q_r;
  blcf_chk_st_t q_nxt;

  // ----------------------------------------------------------------
  // Check sequencer
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt      = q_r;
    q_nxt.done = 1'b0;
    case (q_r.state)
      BLCF_CHK_OFF: begin
        if (mainsGood) begin
          q_nxt.state = BLCF_CHK_SETTLE;
          q_nxt.cnt   = '0;
        end
      end
      BLCF_CHK_SETTLE: begin
        // Backup operation never samples the battery.
        if (!mainsGood) begin
          q_nxt.state = BLCF_CHK_OFF;
        end else if (q_r.cnt == CHK_CNT_W'(SETTLE_CYC - 1)) begin
          q_nxt.state = BLCF_CHK_IDLE;
          q_nxt.done  = 1'b1;
          q_nxt.low   = batteryBelow;
        end else begin
          q_nxt.cnt = q_r.cnt + CHK_CNT_W'(1);
        end
      end
      BLCF_CHK_IDLE: begin
        if (!mainsGood) begin
          q_nxt.state = BLCF_CHK_OFF;
        end
      end
      default: begin
        q_nxt.state = BLCF_CHK_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_r <= '{state: BLCF_CHK_OFF, cnt: '0, done: 1'b0, low: 1'b0};
    end else if (clkEn) begin
      q_r <= q_nxt;
    end
  end

  assign chkDone = q_r.done;
  assign chkLow  = q_r.low;
  assign chkBusy = (q_r.state == BLCF_CHK_SETTLE);

endmodule

// ==== core/blcf_top.sv ====
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module blcf_top
  import blcf_pkg::*;
#(
  parameter int SETTLE_CYC = CHECK_SETTLE_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mainsGood,
  input  wire logic              batteryBelow,
  input  wire logic              yearWrap,
  output logic                   irq,
  output logic                   writeHalt,
  output logic                   counterLoad,
  output logic                   batteryLowFlag,
  output logic                   centuryFlag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addrHit(input logic [APB_AW-1:0] a,
                                   input logic [15:0]       idx);
    addrHit = (a == {idx[APB_AW-3:0], 2'b00});
  endfunction

  function automatic logic [31:0] byteWord(input logic [7:0] b);
    byteWord = {24'h00_0000, b};
  endfunction

  blcf_top_st_t q_r;
  blcf_top_st_t q_nxt;

  logic chkDone;
  logic chkLow;
  logic chkBusy;

  // ----------------------------------------------------------------
  // Power-up battery check
  // ----------------------------------------------------------------
  blcf_batt_check #(
    .SETTLE_CYC   (SETTLE_CYC)
  ) u_check (
    .mclk         (mclk),
    .rst          (rst),
    .clkEn        (clkEn),
    .mainsGood    (mainsGood),
    .batteryBelow (batteryBelow),
    .chkDone      (chkDone),
    .chkLow       (chkLow),
    .chkBusy      (chkBusy)
  );

  // ----------------------------------------------------------------
  // Register and flag logic
  // ----------------------------------------------------------------
  // Read data is registered, so every access has one wait state.
  always_comb begin
    logic             access;
    logic             commit;
    logic             wrLow;
    logic             mapped;
    logic [7:0]       rdByte;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    access     = psel & penable;
    commit     = access & q_r.ready;
    wrLow      = commit & pwrite & pstrb[0];
    mapped     = 1'b0;
    rdByte     = 8'h00;
    ev         = '0;
    clr        = '0;
    q_nxt      = q_r;
    q_nxt.load = 1'b0;
    q_nxt.ready = access & ~q_r.ready;

    if (addrHit(paddr, IDX_IRQ_STAT)) begin
      mapped = 1'b1;
      rdByte[IRQ_W-1:0] = q_r.stat;
    end
    if (addrHit(paddr, IDX_IRQ_MASK)) begin
      mapped = 1'b1;
      rdByte[IRQ_W-1:0] = q_r.mask;
    end
    if (addrHit(paddr, IDX_CHK_STATE)) begin
      mapped = 1'b1;
      rdByte[BIT_CHK_BUSY]   = chkBusy;
      rdByte[BIT_MAINS_GOOD] = mainsGood;
    end
    if (addrHit(paddr, IDX_CONTROL)) begin
      mapped = 1'b1;
      rdByte[BIT_WRITE_HALT] = q_r.writeHalt;
    end
    if (addrHit(paddr, IDX_CLOCK)) begin
      mapped = 1'b1;
      rdByte[BIT_CENT_ENABLE] = q_r.centEnable;
      rdByte[BIT_CENT_FLAG]   = q_r.centFlag;
    end
    if (addrHit(paddr, IDX_FLAGS)) begin
      mapped = 1'b1;
      rdByte[BIT_BATLOW_EN]   = q_r.batLowEn;
      rdByte[BIT_BATLOW_FLAG] = q_r.batLowFlag;
    end

    if (access & ~q_r.ready) begin
      q_nxt.rdata  = pwrite ? ZERO_WORD : byteWord(rdByte);
      q_nxt.slverr = ~mapped;
    end

    // Writes land only at the completing edge of the access.
    if (wrLow & mapped) begin
      if (addrHit(paddr, IDX_IRQ_STAT)) begin
        clr = pwdata[IRQ_W-1:0];
      end
      if (addrHit(paddr, IDX_IRQ_MASK)) begin
        q_nxt.mask = pwdata[IRQ_W-1:0];
      end
      if (addrHit(paddr, IDX_CONTROL)) begin
        q_nxt.writeHalt = pwdata[BIT_WRITE_HALT];
        if (q_r.writeHalt & ~pwdata[BIT_WRITE_HALT]) begin
          q_nxt.load = 1'b1;
        end
      end
      if (addrHit(paddr, IDX_CLOCK)) begin
        q_nxt.centEnable = pwdata[BIT_CENT_ENABLE];
        if (q_r.writeHalt) begin
          q_nxt.centFlag = pwdata[BIT_CENT_FLAG];
        end
      end
      if (addrHit(paddr, IDX_FLAGS)) begin
        // The flag bit position is ignored on write.
        q_nxt.batLowEn = pwdata[BIT_BATLOW_EN];
      end
    end

    // A rollover in the same cycle as a flag write inverts the new value.
    if (yearWrap & q_r.centEnable) begin
      q_nxt.centFlag   = ~q_nxt.centFlag;
      ev[IRQ_CENTURY]  = 1'b1;
    end  // Otherwise the flag holds.

    if (chkDone) begin
      ev[IRQ_CHK_DONE] = 1'b1;
      if (chkLow & q_r.batLowEn) begin
        q_nxt.batLowFlag = 1'b1;
        ev[IRQ_BATLOW]   = 1'b1;
      end else if (~chkLow) begin
        q_nxt.batLowFlag = 1'b0;
      end
    end

    // Set wins over a clear written in the same cycle.
    q_nxt.stat = (q_r.stat & ~clr) | ev;
    q_nxt.irq  = |(q_nxt.stat & q_nxt.mask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_r <= '{ready: 1'b0, rdata: ZERO_WORD, slverr: 1'b0,
               batLowEn: RST_BATLOW_EN, batLowFlag: RST_BATLOW_FLAG,
               centEnable: RST_CENT_ENABLE, centFlag: RST_CENT_FLAG,
               writeHalt: RST_WRITE_HALT, load: 1'b0,
               stat: '0, mask: RST_IRQ_MASK, irq: 1'b0};
    end else if (clkEn) begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = q_r.rdata;
  assign pready         = q_r.ready;
  assign pslverr        = q_r.slverr;
  assign irq            = q_r.irq;
  assign writeHalt      = q_r.writeHalt;
  assign counterLoad    = q_r.load;
  assign batteryLowFlag = q_r.batLowFlag;
  assign centuryFlag    = q_r.centFlag;

endmodule

// ==== sim/blcf_props.sv ====
`timescale 1ns/1ps
module blcf_props
  import blcf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              clkEn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              mainsGood,
  input wire logic              batteryBelow,
  input wire logic              yearWrap,
  input wire logic              writeHalt,
  input wire logic              counterLoad,
  input wire logic              batteryLowFlag,
  input wire logic              centuryFlag
);
  logic wrNow;
  logic centEn_r;
  assign wrNow = psel && penable && pready && pwrite;
  // The enable is not a port, so it is shadowed from completed writes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      centEn_r <= 1'b0;
    end else if (clkEn && wrNow && pstrb[0] &&
                 paddr == {IDX_CLOCK[13:0], 2'b00}) begin
      centEn_r <= pwdata[BIT_CENT_ENABLE];
    end
  end
  default clocking ckDef @(posedge mclk); endclocking
  default disable iff (rst);
  chk_low_rise: assert property (
    $rose(batteryLowFlag) |->
      $past(batteryBelow, 2) && $past(mainsGood, 2))
    else $error("battery-low flag rose without a failing check");
  chk_low_fall: assert property (
    $fell(batteryLowFlag) |->
      !$past(batteryBelow, 2) && $past(mainsGood, 2))
    else $error("battery-low flag fell without a passing check");
  chk_cent_cause: assert property (
    $changed(centuryFlag) |->
      $past(yearWrap) || ($past(wrNow) && $past(writeHalt)))
    else $error("century flag changed without a cause");
  chk_cent_toggle: assert property (
    clkEn && yearWrap && centEn_r && !wrNow |=>
      centuryFlag != $past(centuryFlag))
    else $error("century flag did not invert");
  chk_cent_hold: assert property (
    clkEn && yearWrap && !centEn_r && !wrNow |=> $stable(centuryFlag))
    else $error("century flag moved while disabled");
  chk_halt_cause: assert property (
    $changed(writeHalt) |-> $past(wrNow))
    else $error("write-halt changed without a write");
  chk_load_pulse: assert property (
    counterLoad == $fell(writeHalt))
    else $error("counter load does not match write-halt release");
  chk_apb_wait: assert property (
    psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("slave answer not after one wait state");
endmodule

// ==== sim/blcf_host.sv ====
`timescale 1ns/1ps
module blcf_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // Requests are held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // Only pready seen high or the bench timeout may end this wait.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    pwdata <= ~d;
  endtask
endmodule

// ==== sim/tb_blcf_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  miscompares++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_blcf_top;
  import blcf_pkg::*;
  localparam int SETTLE = 8;
  logic mclk = 0, rst = 1, mainsGood = 0, batteryBelow = 0, yearWrap = 0;
  logic psel, penable, pwrite, pready, pslverr, irq, writeHalt;
  logic counterLoad, batteryLowFlag, centuryFlag, en, fl, halt, cent, anyEn;
  logic clkEn = 1;
  logic [3:0] strb = 4'hF;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  int miscompares = 0, n_compared = 0, cyc = 0;
  initial forever #12.5 mclk = ~mclk;
  blcf_host host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  blcf_top #(.SETTLE_CYC(SETTLE)) DUT (.mclk(mclk), .rst(rst),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mainsGood(mainsGood),
    .batteryBelow(batteryBelow), .yearWrap(yearWrap), .irq(irq),
    .writeHalt(writeHalt), .counterLoad(counterLoad),
    .batteryLowFlag(batteryLowFlag), .centuryFlag(centuryFlag));
  function automatic logic nextCent(logic cur, logic h, logic f);
    return h ? f : cur;
  endfunction
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, {i[13:0], 2'b00}, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] d, logic err);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, {i[13:0], 2'b00}, 32'h0000_0000, q, e);
    `CHK(q, {24'h0, d})
    `CHK(e, err)
  endtask
  task automatic end_of_test;
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded run; a hang counts as a mismatch.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h8663));
    cent = 0;
    anyEn = 0;
    repeat (3) @(posedge mclk);
    rst <= 0;
    rd(IDX_FLAGS, 8'h00, 0);
    rd(IDX_CLOCK, 8'h00, 0);
    wr(IDX_FLAGS, 8'hC0);
    rd(IDX_FLAGS, 8'h80, 0);
    wr(IDX_IRQ_MASK, 8'h01);
    batteryBelow <= 1;
    mainsGood <= 1;
    repeat (SETTLE + 6) @(posedge mclk);
    `CHK(batteryLowFlag, 1'b1)
    `CHK(irq, 1'b1)
    rd(IDX_FLAGS, 8'hC0, 0);
    rd(IDX_IRQ_STAT, 8'h05, 0);
    wr(IDX_IRQ_STAT, 8'h05);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(IDX_FLAGS, 8'h80);
    mainsGood <= 0;
    batteryBelow <= 0;
    repeat (SETTLE + 6) @(posedge mclk);
    rd(IDX_FLAGS, 8'hC0, 0);
    rd(IDX_CHK_STATE, 8'h00, 0);
    mainsGood <= 1;
    rd(IDX_CHK_STATE, 8'h03, 0);
    repeat (SETTLE + 6) @(posedge mclk);
    rd(IDX_FLAGS, 8'h80, 0);
    for (int i = 0; i < 12; i++) begin
      {en, fl, halt} = 3'($urandom);
      wr(IDX_CONTROL, {halt, 7'h00});
      rd(IDX_CONTROL, {halt, 7'h00}, 0);
      `CHK(writeHalt, halt)
      wr(IDX_CLOCK, {2'b00, en, fl, 4'h0});
      cent = nextCent(cent, halt, fl);
      rd(IDX_CLOCK, {2'b00, en, cent, 4'h0}, 0);
      wr(IDX_CONTROL, 8'h00);
      yearWrap <= 1;
      @(posedge mclk);
      yearWrap <= 0;
      `CHK(counterLoad, halt)
      cent = cent ^ en;
      anyEn = anyEn | en;
      @(posedge mclk);
      `CHK(centuryFlag, cent)
    end
    // A write without the low byte strobe must leave the register alone.
    strb <= 4'h0;
    wr(IDX_CLOCK, {2'b00, ~en, ~cent, 4'h0});
    strb <= 4'hF;
    rd(IDX_CLOCK, {2'b00, en, cent, 4'h0}, 0);
    // A rollover while the clock enable is low must be lost.
    wr(IDX_CLOCK, 8'h20);
    clkEn <= 0;
    yearWrap <= 1;
    repeat (2) @(posedge mclk);
    yearWrap <= 0;
    clkEn <= 1;
    @(posedge mclk);
    `CHK(centuryFlag, cent)
    rd(IDX_IRQ_STAT, {5'h00, anyEn, 2'h2}, 0);
    rd(16'h0100, 8'h00, 1);
    end_of_test();
  end
endmodule
bind blcf_top blcf_props u_props (.mclk(mclk), .rst(rst), .clkEn(clkEn),
  .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .mainsGood(mainsGood), .batteryBelow(batteryBelow),
  .yearWrap(yearWrap), .writeHalt(writeHalt), .counterLoad(counterLoad),
  .batteryLowFlag(batteryLowFlag), .centuryFlag(centuryFlag));
